/* File: rtl/cmts_chan.sv */
`timescale 1ns/1ps
module cmts_chan
   import cmts_pkg::*;
(
   // Clock, reset and freeze.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Configuration.
   input wire logic [3:0] mode,
   input wire logic rst_en,
   input wire logic [CMTS_CW-1:0] compare_value_pair,
   input wire logic [CMTS_CW-1:0] first_timer_count,
   // Results.
   output logic channel_output_pin,
   output logic match_evt,
   output logic timer_clr_req
);

   typedef struct packed {
      logic out;
      logic prev_eq;
      logic pulse_on;
   } cmts_chan_st_t;

   cmts_chan_st_t s_r;
   cmts_chan_st_t s_nxt;
   logic eq;
   logic rise;
   logic active;

   // Equality is checked every cycle; only the entry into equality counts.
   assign eq = (compare_value_pair == first_timer_count);
   assign rise = eq & ~s_r.prev_eq;
   assign active = (mode == CMTS_MODE_TOGGLE) || (mode == CMTS_MODE_SET) ||
                   (mode == CMTS_MODE_CLEAR) || (mode == CMTS_MODE_PULSE) ||
                   (mode == CMTS_MODE_EVENT);
   assign match_evt = rise & active;
   assign timer_clr_req = match_evt & rst_en;

   // Pin action chosen by the mode field, one action per match.
   always_comb begin
      s_nxt = s_r;
      s_nxt.prev_eq = eq;
      if (s_r.pulse_on) begin
         s_nxt.out = 1'b0;
         s_nxt.pulse_on = 1'b0;
      end
      if (match_evt) begin
         case (mode)
            CMTS_MODE_TOGGLE: s_nxt.out = ~s_r.out;
            CMTS_MODE_SET: s_nxt.out = 1'b1;
            CMTS_MODE_CLEAR: s_nxt.out = 1'b0;
            CMTS_MODE_PULSE: begin
               s_nxt.out = 1'b1;
               s_nxt.pulse_on = 1'b1;
            end
            CMTS_MODE_EVENT: s_nxt.out = s_r.out;
            default: s_nxt.out = s_r.out;
         endcase
      end
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign channel_output_pin = s_r.out;

endmodule : cmts_chan

/* File: rtl/cmts_pkg.sv */
package cmts_pkg;

   // Number of compare channels and the width of the compare path.
   localparam int CMTS_NCH = 2;
   localparam int CMTS_CW = 16;

   // Number of period-timer select fields in the selection register.
   localparam int CMTS_NSEL = 4;

   // Register byte offsets on the APB side.
   localparam logic [7:0] CMTS_OFF_TSEL = 8'h00;
   localparam logic [7:0] CMTS_OFF_TCTRL = 8'h04;
   localparam logic [7:0] CMTS_OFF_TCOUNT = 8'h08;
   localparam logic [7:0] CMTS_OFF_STATUS = 8'h0C;
   localparam logic [7:0] CMTS_OFF_MASK = 8'h10;
   localparam logic [7:0] CMTS_OFF_CH_BASE = 8'h14;
   localparam logic [7:0] CMTS_CH_STRIDE = 8'h08;
   localparam logic [7:0] CMTS_OFF_CH_CMP = 8'h04;

   // Field positions.
   localparam int CMTS_TCTRL_RUN_BIT = 0;
   localparam int CMTS_TCTRL_CLR_BIT = 1;
   localparam int CMTS_CTRL_RST_BIT = 4;
   localparam int CMTS_CTRL_OUT_BIT = 8;

   // Values after reset.
   localparam logic [7:0] CMTS_TSEL_RST = 8'h00;
   localparam logic CMTS_RUN_RST = 1'b1;
   localparam logic [3:0] CMTS_MODE_RST = 4'h0;
   localparam logic [15:0] CMTS_CMP_RST = 16'h0000;
   localparam logic [15:0] CMTS_COUNT_RST = 16'h0000;

   // Compare mode codes held in the channel control register.
   localparam logic [3:0] CMTS_MODE_OFF = 4'h0;
   localparam logic [3:0] CMTS_MODE_TOGGLE = 4'h1;
   localparam logic [3:0] CMTS_MODE_SET = 4'h2;
   localparam logic [3:0] CMTS_MODE_CLEAR = 4'h3;
   localparam logic [3:0] CMTS_MODE_PULSE = 4'h4;
   localparam logic [3:0] CMTS_MODE_EVENT = 4'h5;

   // Period timer select codes.
   localparam logic [1:0] CMTS_SEL_TIMER_A = 2'h0;
   localparam logic [1:0] CMTS_SEL_TIMER_B = 2'h1;
   localparam logic [1:0] CMTS_SEL_TIMER_C = 2'h2;

endpackage : cmts_pkg

/* File: rtl/cmts_timer.sv */
`timescale 1ns/1ps
module cmts_timer
   import cmts_pkg::*;
(
   // Clock, reset and freeze.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Timer link.
   cmts_tmr_if.tmr_mp tif
);

   typedef struct packed {
      logic [CMTS_CW-1:0] count;
   } cmts_tmr_st_t;

   cmts_tmr_st_t s_r;
   cmts_tmr_st_t s_nxt;

   // A clear request wins over counting so a match reset is never missed.
   always_comb begin
      s_nxt = s_r;
      if (tif.clear) begin
         s_nxt.count = CMTS_COUNT_RST;
      end else if (tif.run) begin
         s_nxt.count = s_r.count + 16'h0001;
      end
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign tif.count = s_r.count;

endmodule : cmts_timer

/* File: rtl/cmts_tmr_if.sv */
`timescale 1ns/1ps
interface cmts_tmr_if;
   import cmts_pkg::*;

   // Run enable and synchronous clear toward the timer, count back.
   logic run;
   logic clear;
   logic [CMTS_CW-1:0] count;

   modport tmr_mp (input run, input clear, output count);
   modport user_mp (output run, output clear, input count);
endinterface : cmts_tmr_if

/* File: rtl/cmts_top.sv */
// How it works
// - Each channel compares its 16-bit compare value with the timer count every cycle.
// - A match toggles, sets, clears, pulses or only signals; may also reset the timer.
// - The 4-bit mode field of the channel control register picks the action.
// - The interrupt flag is set on the same edge that applies the action.
// - The event-only mode leaves the pin alone and only raises the flag.
// - All channels are the same module, built by one generate loop.
// - Each 2-bit select field picks base timer A, B or C; code 11 selects none.
`timescale 1ns/1ps
module cmts_top
   import cmts_pkg::*;
(
   // Clock, reset and freeze.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Channel outputs.
   output logic [CMTS_NCH-1:0] channel_output_pin,
   output logic [CMTS_NCH-1:0] compare_match_evt,
   output logic irq,
   // Period timer selection.
   output logic [1:0] pwm_ch4_timer_sel,
   output logic [1:0] pwm_ch3_timer_sel,
   output logic [1:0] cmp_ch2_timer_sel,
   output logic [1:0] cmp_ch1_timer_sel,
   output logic [CMTS_NSEL-1:0][2:0] period_timer_onehot
);

   typedef struct packed {
      logic [7:0] tsel;
      logic [CMTS_NSEL-1:0][2:0] onehot;
      logic run;
      logic tclr;
      logic [CMTS_NCH-1:0][3:0] mode;
      logic [CMTS_NCH-1:0] rst_en;
      logic [CMTS_NCH-1:0][CMTS_CW-1:0] cmp;
      logic [CMTS_NCH-1:0] status;
      logic [CMTS_NCH-1:0] mask;
      logic [31:0] prdata;
      logic pslverr;
   } cmts_top_st_t;

   cmts_top_st_t s_r;
   cmts_top_st_t s_nxt;

   // Per-channel results.
   logic [CMTS_NCH-1:0] evt;
   logic [CMTS_NCH-1:0] clr_req;
   logic [CMTS_NCH-1:0] out_lvl;

   // Bus phase decode.
   logic setup_ph;
   logic wr_access;
   logic [31:0] rd_data;
   logic addr_hit;
   logic [CMTS_NCH-1:0] w1c;

   cmts_tmr_if tif ();

   // Byte address of a channel's control register.
   function automatic logic [7:0] ch_ctrl_addr(input int idx);
      logic [7:0] base;
      base = CMTS_OFF_CH_BASE + (8'(idx) * CMTS_CH_STRIDE);
      return base;
   endfunction : ch_ctrl_addr

   // Byte address of a channel's compare value register.
   function automatic logic [7:0] ch_cmp_addr(input int idx);
      logic [7:0] base;
      base = ch_ctrl_addr(idx) + CMTS_OFF_CH_CMP;
      return base;
   endfunction : ch_cmp_addr

   // Decode of one select field into a one-hot timer choice.
   function automatic logic [2:0] sel_decode(input logic [1:0] code);
      logic [2:0] hot;
      case (code)
         CMTS_SEL_TIMER_A: hot = 3'h1;
         CMTS_SEL_TIMER_B: hot = 3'h2;
         CMTS_SEL_TIMER_C: hot = 3'h4;
         default: hot = 3'h0;
      endcase
      return hot;
   endfunction : sel_decode

   // The first timer shared by all channels.
   cmts_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .tif(tif)
   );

   // Timer clear comes from a software strobe or any channel match reset.
   assign tif.run = s_r.run;
   assign tif.clear = s_r.tclr | (|clr_req);

   // One identical compare channel per slot.
   for (genvar g = 0; g < CMTS_NCH; g++) begin : g_ch
      cmts_chan u_chan (
         .pclk(pclk),
         .presetn(presetn),
         .ce(ce),
         .mode(s_r.mode[g]),
         .rst_en(s_r.rst_en[g]),
         .compare_value_pair(s_r.cmp[g]),
         .first_timer_count(tif.count),
         .channel_output_pin(out_lvl[g]),
         .match_evt(evt[g]),
         .timer_clr_req(clr_req[g])
      );
   end

   // Setup phase captures read data; access phase commits a write.
   assign setup_ph = psel & ~penable;
   assign wr_access = psel & penable & pwrite;

   // Address decode and read multiplexer.
   always_comb begin
      rd_data = 32'h0000_0000;
      addr_hit = 1'b0;
      case (paddr)
         CMTS_OFF_TSEL: begin
            rd_data[7:0] = s_r.tsel;
            addr_hit = 1'b1;
         end
         CMTS_OFF_TCTRL: begin
            rd_data[CMTS_TCTRL_RUN_BIT] = s_r.run;
            addr_hit = 1'b1;
         end
         CMTS_OFF_TCOUNT: begin
            rd_data[CMTS_CW-1:0] = tif.count;
            addr_hit = 1'b1;
         end
         CMTS_OFF_STATUS: begin
            rd_data[CMTS_NCH-1:0] = s_r.status;
            addr_hit = 1'b1;
         end
         CMTS_OFF_MASK: begin
            rd_data[CMTS_NCH-1:0] = s_r.mask;
            addr_hit = 1'b1;
         end
         default: begin
            rd_data = 32'h0000_0000;
            addr_hit = 1'b0;
         end
      endcase
      for (int i = 0; i < CMTS_NCH; i++) begin
         if (paddr == ch_ctrl_addr(i)) begin
            rd_data[3:0] = s_r.mode[i];
            rd_data[CMTS_CTRL_RST_BIT] = s_r.rst_en[i];
            rd_data[CMTS_CTRL_OUT_BIT] = out_lvl[i];
            addr_hit = 1'b1;
         end
         if (paddr == ch_cmp_addr(i)) begin
            rd_data[CMTS_CW-1:0] = s_r.cmp[i];
            addr_hit = 1'b1;
         end
      end
   end

   // Write-one-to-clear mask for the status register.
   assign w1c = (wr_access && paddr == CMTS_OFF_STATUS) ? pwdata[CMTS_NCH-1:0] : '0;

   // Register updates.
   always_comb begin
      s_nxt = s_r;
      s_nxt.tclr = 1'b0;
      // Read data and error are captured in the setup cycle.
      if (setup_ph) begin
         s_nxt.prdata = pwrite ? 32'h0000_0000 : rd_data;
         s_nxt.pslverr = ~addr_hit;
      end
      if (wr_access) begin
         case (paddr)
            CMTS_OFF_TSEL: s_nxt.tsel = pwdata[7:0];
            CMTS_OFF_TCTRL: begin
               s_nxt.run = pwdata[CMTS_TCTRL_RUN_BIT];
               s_nxt.tclr = pwdata[CMTS_TCTRL_CLR_BIT];
            end
            CMTS_OFF_MASK: s_nxt.mask = pwdata[CMTS_NCH-1:0];
            default: s_nxt.tsel = s_r.tsel;
         endcase
         for (int i = 0; i < CMTS_NCH; i++) begin
            if (paddr == ch_ctrl_addr(i)) begin
               s_nxt.mode[i] = pwdata[3:0];
               s_nxt.rst_en[i] = pwdata[CMTS_CTRL_RST_BIT];
            end
            if (paddr == ch_cmp_addr(i)) begin
               s_nxt.cmp[i] = pwdata[CMTS_CW-1:0];
            end
         end
      end
      // A match in the clearing cycle keeps its flag set.
      s_nxt.status = (s_r.status & ~w1c) | evt;
      // Timer choice per select field, two bits each from the bottom.
      for (int f = 0; f < CMTS_NSEL; f++) begin
         s_nxt.onehot[f] = sel_decode(s_nxt.tsel[2*f +: 2]);
      end
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r.tsel <= CMTS_TSEL_RST;
         s_r.onehot <= {CMTS_NSEL{3'h1}};
         s_r.run <= CMTS_RUN_RST;
         s_r.tclr <= 1'b0;
         s_r.mode <= {CMTS_NCH{CMTS_MODE_RST}};
         s_r.rst_en <= '0;
         s_r.cmp <= {CMTS_NCH{CMTS_CMP_RST}};
         s_r.status <= '0;
         s_r.mask <= '0;
         s_r.prdata <= 32'h0000_0000;
         s_r.pslverr <= 1'b0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // Bus answers: no wait states except while frozen.
   assign pready = ce;
   assign prdata = s_r.prdata;
   assign pslverr = s_r.pslverr;

   // Channel and interrupt outputs.
   assign channel_output_pin = out_lvl;
   assign compare_match_evt = evt;
   assign irq = |(s_r.status & s_r.mask);

   // Select fields straight from the register.
   assign pwm_ch4_timer_sel = s_r.tsel[7:6];
   assign pwm_ch3_timer_sel = s_r.tsel[5:4];
   assign cmp_ch2_timer_sel = s_r.tsel[3:2];
   assign cmp_ch1_timer_sel = s_r.tsel[1:0];
   assign period_timer_onehot = s_r.onehot;

endmodule : cmts_top

/* File: tb/cmts_pin_load.sv */
`timescale 1ns/1ps
module cmts_pin_load (
   // Clock and channel pins.
   input wire logic pclk,
   input wire logic [1:0] pin,
   // Count of pin changes.
   output int edges
);
   logic [1:0] last_r;
   // Start with a quiet load and pins at their reset level.
   initial begin
      edges = 0;
      last_r = 2'h0;
   end
   // The pins are driven outputs, so every sampled change is one load transition.
   always @(posedge pclk) begin
      if (pin !== last_r) begin
         edges <= edges + 1;
      end
      last_r <= pin;
   end
endmodule : cmts_pin_load

/* File: tb/cmts_top_sva.sv */
`timescale 1ns/1ps
module cmts_sva
   import cmts_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Channel side.
   input wire logic [CMTS_NCH-1:0] channel_output_pin,
   input wire logic [CMTS_NCH-1:0] compare_match_evt,
   input wire logic irq,
   // Timer selection.
   input wire logic [1:0] pwm_ch4_timer_sel,
   input wire logic [1:0] pwm_ch3_timer_sel,
   input wire logic [1:0] cmp_ch2_timer_sel,
   input wire logic [1:0] cmp_ch1_timer_sel,
   input wire logic [CMTS_NSEL-1:0][2:0] period_timer_onehot
);
   logic [CMTS_NSEL-1:0][2:0] exp_oh;
   // Reserved code selects no timer.
   function automatic logic [2:0] dec(input logic [1:0] s);
      return (s == 2'h3) ? 3'h0 : 3'h1 << s;
   endfunction : dec
   // Expected one-hot selection from the four fields.
   assign exp_oh = {dec(pwm_ch4_timer_sel), dec(pwm_ch3_timer_sel),
      dec(cmp_ch2_timer_sel), dec(cmp_ch1_timer_sel)};
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_pin_rise: assert property ($rose(channel_output_pin[0]) |->
      $past(compare_match_evt[0])) else $error("pin rose without a match");
   a_pin_fall: assert property ($fell(channel_output_pin[0]) |->
      $past(compare_match_evt[0]) || $past(compare_match_evt[0], 2))
      else $error("pin fell without a match");
   a_pin1_rise: assert property ($rose(channel_output_pin[1]) |->
      $past(compare_match_evt[1])) else $error("second pin rose without a match");
   a_evt_once: assert property (compare_match_evt[0] |=>
      !compare_match_evt[0]) else $error("match event repeated");
   a_evt1_once: assert property (compare_match_evt[1] |=>
      !compare_match_evt[1]) else $error("second match event repeated");
   a_irq_cause: assert property ($rose(irq) |-> $past(|compare_match_evt) ||
      $past(psel && penable && pwrite)) else $error("irq rose without cause");
   a_sel_decode: assert property ($stable(exp_oh) && $stable(period_timer_onehot)
      |-> period_timer_onehot == exp_oh) else $error("timer select decode wrong");
   a_err_unmap: assert property (psel && penable && paddr > 8'h20 |->
      pslverr && prdata == 32'h0) else $error("unmapped access not refused");
   a_sel_access: assert property (psel && penable && paddr == CMTS_OFF_TSEL |->
      !pslverr && (pwrite || prdata[31:8] == 24'h0)) else $error("select access wrong");
   c_pulse: cover property ($rose(channel_output_pin[0]) ##1 $fell(channel_output_pin[0]));
   c_evt1: cover property (compare_match_evt[1]);
   c_irq: cover property ($rose(irq));
endmodule : cmts_sva
bind cmts_top cmts_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
   .pslverr, .channel_output_pin, .compare_match_evt, .irq, .pwm_ch4_timer_sel,
   .pwm_ch3_timer_sel, .cmp_ch2_timer_sel, .cmp_ch1_timer_sel, .period_timer_onehot);

/* File: tb/compare_match_timer_select_tb.sv */
`timescale 1ns/1ps
module compare_match_timer_select_tb
   import cmts_pkg::*;
();
   localparam logic [7:0] c0_ctl = CMTS_OFF_CH_BASE;
   localparam logic [7:0] c0_cmp = CMTS_OFF_CH_BASE + CMTS_OFF_CH_CMP;
   localparam logic [7:0] c1_ctl = CMTS_OFF_CH_BASE + CMTS_CH_STRIDE;
   localparam logic [7:0] c1_cmp = c1_ctl + CMTS_OFF_CH_CMP;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, errv;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [1:0] channel_output_pin, compare_match_evt;
   logic [1:0] pwm_ch4_timer_sel, pwm_ch3_timer_sel, cmp_ch2_timer_sel, cmp_ch1_timer_sel;
   logic [CMTS_NSEL-1:0][2:0] period_timer_onehot;
   int err_total, n_tests, edges;
   // Design and the load on its pins.
   cmts_top dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .channel_output_pin, .compare_match_evt, .irq, .pwm_ch4_timer_sel,
      .pwm_ch3_timer_sel, .cmp_ch2_timer_sel, .cmp_ch1_timer_sel, .period_timer_onehot);
   cmts_pin_load load (.pclk, .pin(channel_output_pin), .edges);
   // Free-running bus clock.
   always #50 pclk = ~pclk;
   task automatic close_out();
      if (err_total == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; it ends one idle edge later so the next setup never collides.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         err_total++;
         close_out();
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   // Waits for the first channel's match pulse, settled after the edge.
   task automatic wait_evt();
      int i;
      for (i = 0; i < 200; i++) begin
         @(posedge pclk);
         #1;
         if (compare_match_evt[0] === 1'b1) break;
      end
      if (i == 200) begin
         err_total++;
         close_out();
      end
   endtask : wait_evt
   // Selection register reset, layout, decode and an unmapped access.
   task automatic t_regs();
      apb(1'b0, CMTS_OFF_TSEL, 32'h0);
      chk(rdv, 32'h0);
      apb(1'b1, CMTS_OFF_TSEL, 32'h0000_00E4);
      apb(1'b0, CMTS_OFF_TSEL, 32'h0);
      chk(rdv, 32'h0000_00E4);
      chk({pwm_ch4_timer_sel, pwm_ch3_timer_sel, cmp_ch2_timer_sel, cmp_ch1_timer_sel},
         8'hE4);
      chk(period_timer_onehot, 12'h111);
      apb(1'b0, 8'h40, 32'h0);
      chk(errv, 1'b1);
      chk(rdv, 32'h0);
   endtask : t_regs
   // Every active mode on the first channel, with timer reset on match.
   task automatic t_modes();
      logic [3:0] md [5];
      int k;
      logic p;
      logic e;
      md = '{CMTS_MODE_SET, CMTS_MODE_EVENT, CMTS_MODE_CLEAR, CMTS_MODE_TOGGLE,
         CMTS_MODE_PULSE};
      apb(1'b1, CMTS_OFF_MASK, 32'h0000_0001);
      apb(1'b1, c0_cmp, 32'h0000_0010);
      for (k = 0; k < 5; k++) begin
         apb(1'b1, c0_ctl, {27'h0, 1'b1, md[k]});
         apb(1'b1, CMTS_OFF_STATUS, 32'h0000_0001);
         // Restart the count from zero so the match comes long before a 16-bit wrap.
         apb(1'b1, CMTS_OFF_TCTRL, 32'h0000_0003);
         wait_evt();
         p = channel_output_pin[0];
         e = (md[k] == CMTS_MODE_SET) | (md[k] == CMTS_MODE_PULSE) |
            ((md[k] == CMTS_MODE_EVENT) & p) | ((md[k] == CMTS_MODE_TOGGLE) & !p);
         @(posedge pclk);
         #1;
         chk(channel_output_pin[0], e);
         chk(irq, 1'b1);
         if (md[k] == CMTS_MODE_PULSE) begin
            @(posedge pclk);
            #1;
            chk(channel_output_pin[0], 1'b0);
         end
         @(posedge pclk);
      end
      apb(1'b0, CMTS_OFF_TCOUNT, 32'h0);
      chk(rdv <= 32'h0000_0010, 1'b1);
      apb(1'b1, CMTS_OFF_MASK, 32'h0);
      chk(irq, 1'b0);
      apb(1'b1, c0_ctl, 32'h0000_0007);
      apb(1'b1, CMTS_OFF_STATUS, 32'h0000_0001);
      repeat (40) @(posedge pclk);
      apb(1'b0, CMTS_OFF_STATUS, 32'h0);
      chk(rdv, 32'h0);
   endtask : t_modes
   // Frozen count on the second channel: a held equality acts only once.
   task automatic t_once();
      int e0;
      e0 = edges;
      apb(1'b1, CMTS_OFF_TCTRL, 32'h0);
      apb(1'b1, CMTS_OFF_TCTRL, 32'h0000_0002);
      apb(1'b1, c1_cmp, 32'h0000_0005);
      apb(1'b1, c1_ctl, {28'h0, CMTS_MODE_TOGGLE});
      apb(1'b1, c1_cmp, 32'h0);
      repeat (30) @(posedge pclk);
      chk(edges - e0, 32'h0000_0001);
      chk(channel_output_pin, 2'h2);
      apb(1'b0, CMTS_OFF_STATUS, 32'h0);
      chk(rdv, 32'h0000_0002);
      apb(1'b1, CMTS_OFF_TCTRL, 32'h0000_0001);
   endtask : t_once
   // Reset, then the scenarios in turn.
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      err_total = 0;
      n_tests = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_modes();
      t_once();
      close_out();
   end
endmodule : compare_match_timer_select_tb
